// file: hw/pes_sequencer.sv
`timescale 1ns/1ps
// Notes on behaviour
// - door close or power-up enters warm-up
// - warm-up discharges, phases, cleans, senses, calibrates
// - after warm-up or last rotation wait idle
// - sleep command in either rotation returns engine to idle period
// - idle calibrations run only on formatter command
// - print command starts initial rotation until pickup
// - printing lasts until fuser trailing edge seen
// - stabilise on print-count interval or trigger
// - last rotation ejects sheet until motor stops
// - print during last rotation skips idle period
module pes_sequencer (
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	input wire logic print_cmd_in,
	input wire logic sleep_cmd_in,
	input wire logic reg_cal_cmd_in,
	input wire logic stab_cal_cmd_in,
	input wire logic stab_time_in,
	input wire logic [pes_pkg::INTERVAL_W-1:0] stab_interval_in,
	input wire logic door_closed_in,
	input wire logic phase_done_in,
	input wire logic paper_picked_in,
	input wire logic fuser_paper_in,
	input wire logic motor_stopped_in,
	input wire logic cal_done_in,
	output pes_pkg::pes_period_type period_out,
	output logic drum_discharge_out,
	output logic phase_adjust_out,
	output logic belt_clean_out,
	output logic supply_sense_out,
	output logic reg_cal_run_out,
	output logic stab_cal_run_out,
	output logic motor_run_out,
	output logic pickup_out,
	output logic image_form_out,
	output logic engine_ready_out,
	output logic sleeping_out
);
	import pes_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// state of the sequencer
	typedef struct packed {
		pes_period_type period;
		logic reg_pend;
		logic stab_pend;
		logic print_pend;
		logic reg_run;
		logic stab_run;
		logic sleeping;
		logic discharge;
		logic phase_adj;
		logic belt_clean;
		logic sense;
		logic motor;
		logic pickup;
		logic image;
		logic ready;
	} pes_seq_type;

	pes_seq_type cur;
	pes_seq_type next_cur;

	logic [SENSE_W-1:0] raw_sense;
	logic [SENSE_W-1:0] sense_level;
	logic [SENSE_W-1:0] sense_rise;
	logic [SENSE_W-1:0] sense_fall;
	logic sheet_done;
	logic stab_due;

	// reset value of the whole state
	function automatic pes_seq_type reset_state();
		pes_seq_type s;
		s = '0;
		s.period = PERIOD_RST;
		return s;
	endfunction

	// true while either calibration is in progress
	function automatic logic cal_busy(input pes_seq_type s);
		return s.reg_run | s.stab_run;
	endfunction

	// start the stability run now, or hold it pending while another run owns the engine
	function automatic pes_seq_type request_stab(input pes_seq_type s);
		pes_seq_type d;
		d = s;
		if (cal_busy(s)) begin
			d.stab_pend = 1'b1;
		end else begin
			d.stab_run = 1'b1;
		end
		return d;
	endfunction

	// output levels of a period; phase drive stops once the synced feedback reports done
	function automatic pes_seq_type drive_levels(input pes_seq_type s, input logic phased);
		pes_seq_type d;
		d = s;
		d.discharge = 1'b0;
		d.phase_adj = 1'b0;
		d.belt_clean = 1'b0;
		d.sense = 1'b0;
		d.motor = 1'b0;
		d.pickup = 1'b0;
		d.image = 1'b0;
		d.ready = 1'b0;
		unique case (s.period)
			warm_up_period: begin
				d.discharge = 1'b1;
				d.phase_adj = !phased;
				d.belt_clean = 1'b1;
				d.sense = 1'b1;
				d.motor = 1'b1;
			end
			idle_ready_period: begin
				d.ready = 1'b1;
			end
			initial_rotation_period: begin
				d.motor = 1'b1;
				d.pickup = 1'b1;
			end
			printing_period: begin
				d.motor = 1'b1;
				d.image = 1'b1;
			end
			last_rotation_period: begin
				d.motor = 1'b0;
			end
			default: begin
				d.motor = 1'b0; // an illegal code drives nothing
			end
		endcase
		return d;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// engine feedback pins pass three flops before use
	assign raw_sense[SNS_DOOR] = door_closed_in;
	assign raw_sense[SNS_PHASE] = phase_done_in;
	assign raw_sense[SNS_PICK] = paper_picked_in;
	assign raw_sense[SNS_FUSER] = fuser_paper_in;
	assign raw_sense[SNS_MOTOR] = motor_stopped_in;
	assign raw_sense[SNS_CAL] = cal_done_in;

	pes_sync u_sync (
		.ref_clk_in(ref_clk_in),
		.sys_rst_in(sys_rst_in),
		.async_in(raw_sense),
		.level_out(sense_level),
		.rise_out(sense_rise),
		.fall_out(sense_fall)
	);

	// a sheet is finished when its trailing edge leaves the fuser sensor while printing
	assign sheet_done = sense_fall[SNS_FUSER] && (cur.period == printing_period);

	pes_interval u_interval (
		.ref_clk_in(ref_clk_in),
		.sys_rst_in(sys_rst_in),
		.sheet_done_in(sheet_done),
		.interval_in(stab_interval_in),
		.due_out(stab_due)
	);

	////////////////////////////////////////////////////////////////////////////////
	// period sequencing and calibration bookkeeping
	always_comb begin
		next_cur = cur;

		// a finished calibration frees the engine for the next one
		if (sense_rise[SNS_CAL]) begin
			next_cur.reg_run = 1'b0;
			next_cur.stab_run = 1'b0;
		end

		unique case (cur.period)
			warm_up_period: begin
				// start pending calibrations one at a time, registration first
				if (!cal_busy(next_cur) && cur.reg_pend) begin
					next_cur.reg_pend = 1'b0;
					next_cur.reg_run = 1'b1;
				end else if (!cal_busy(next_cur) && cur.stab_pend) begin
					next_cur.stab_pend = 1'b0;
					next_cur.stab_run = 1'b1;
				end
				// leave once the drum is phased and no calibration remains
				if (sense_level[SNS_PHASE] && !cal_busy(cur) && !cur.reg_pend &&
						!cur.stab_pend) begin
					next_cur.period = idle_ready_period;
				end
			end
			idle_ready_period: begin
				// calibrations in idle only when commanded, one at a time
				if (reg_cal_cmd_in && !cal_busy(next_cur)) begin
					next_cur.reg_run = 1'b1;
				end else if (stab_cal_cmd_in && !cal_busy(next_cur)) begin
					next_cur.stab_run = 1'b1;
				end
				if (sleep_cmd_in) begin
					next_cur.sleeping = 1'b1;
				end
				// a print request waits for a running calibration to end
				if ((print_cmd_in || cur.print_pend) && !cal_busy(next_cur)) begin
					next_cur.print_pend = 1'b0;
					next_cur.sleeping = 1'b0;
					next_cur.period = initial_rotation_period;
				end
			end
			initial_rotation_period: begin
				if (sleep_cmd_in) begin
					next_cur.sleeping = 1'b1;
					next_cur.period = idle_ready_period;
				end else if (sense_rise[SNS_PICK]) begin
					next_cur.period = printing_period;
				end
			end
			printing_period: begin
				// stabilise on the interval or an external trigger time
				if (stab_due || stab_time_in) begin
					next_cur = request_stab(next_cur);
				end
				if (sense_fall[SNS_FUSER]) begin
					next_cur.period = last_rotation_period;
				end
			end
			last_rotation_period: begin
				if (print_cmd_in) begin
					next_cur.period = initial_rotation_period;
				end else if (sleep_cmd_in) begin
					next_cur.sleeping = 1'b1;
					next_cur.period = idle_ready_period;
				end else if (sense_level[SNS_MOTOR]) begin
					next_cur.period = idle_ready_period;
				end
			end
			default: begin
				next_cur.period = warm_up_period; // illegal code recovers to warm-up
			end
		endcase

		// the interval pulse lands just after the trailing edge has ended printing
		if (stab_due && cur.period != printing_period) begin
			next_cur = request_stab(next_cur);
		end

		// print requests seen while the idle period is busy are remembered
		if (print_cmd_in && cur.period == idle_ready_period &&
				next_cur.period == idle_ready_period) begin
			next_cur.print_pend = 1'b1;
		end

		// commands outside idle are held for the next warm-up; set wins over start
		if (reg_cal_cmd_in && cur.period != idle_ready_period) begin
			next_cur.reg_pend = 1'b1;
		end
		if (stab_cal_cmd_in && cur.period != idle_ready_period) begin
			next_cur.stab_pend = 1'b1;
		end

		// a closing door restarts warm-up from any period
		if (sense_rise[SNS_DOOR]) begin
			next_cur.period = warm_up_period;
			next_cur.reg_pend = next_cur.reg_pend | next_cur.reg_run;
			next_cur.stab_pend = next_cur.stab_pend | next_cur.stab_run;
			next_cur.reg_run = 1'b0;
			next_cur.stab_run = 1'b0;
			next_cur.print_pend = 1'b0;
			next_cur.sleeping = 1'b0;
		end

		// output levels follow the next period so they change with it
		next_cur = drive_levels(next_cur, sense_level[SNS_PHASE]);
	end

	////////////////////////////////////////////////////////////////////////////////
	// register the state; power-on reset lands in warm-up
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			cur <= reset_state();
		end else begin
			cur <= next_cur;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs straight from the state flops
	assign period_out = cur.period;
	assign drum_discharge_out = cur.discharge;
	assign phase_adjust_out = cur.phase_adj;
	assign belt_clean_out = cur.belt_clean;
	assign supply_sense_out = cur.sense;
	assign reg_cal_run_out = cur.reg_run;
	assign stab_cal_run_out = cur.stab_run;
	assign motor_run_out = cur.motor;
	assign pickup_out = cur.pickup;
	assign image_form_out = cur.image;
	assign engine_ready_out = cur.ready;
	assign sleeping_out = cur.sleeping;

endmodule

// file: hw/pes_pkg.sv
package pes_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// engine feedback inputs, packed into one vector for synchronising
	localparam int unsigned SENSE_W = 6;
	localparam int unsigned SNS_DOOR = 0; // door closed level
	localparam int unsigned SNS_PHASE = 1; // drum phase adjustment complete
	localparam int unsigned SNS_PICK = 2; // sheet picked up
	localparam int unsigned SNS_FUSER = 3; // fuser paper sensor, high while paper present
	localparam int unsigned SNS_MOTOR = 4; // motor stopped level
	localparam int unsigned SNS_CAL = 5; // calibration / stabilisation finished

	////////////////////////////////////////////////////////////////////////////////
	// print-count interval for image stabilisation
	localparam int unsigned INTERVAL_W = 8;
	localparam logic [INTERVAL_W-1:0] COUNT_RST = 8'h00;
	localparam logic [INTERVAL_W-1:0] COUNT_ONE = 8'h01;
	localparam logic [INTERVAL_W-1:0] INTERVAL_OFF = 8'h00; // zero disables the interval
	localparam logic [SENSE_W-1:0] SENSE_RST = 6'h00;

	////////////////////////////////////////////////////////////////////////////////
	// operating periods, gray coded along the normal path from warm-up through last rotation
	typedef enum logic [2:0] {
		warm_up_period = 3'h0,
		idle_ready_period = 3'h1,
		initial_rotation_period = 3'h3,
		printing_period = 3'h2,
		last_rotation_period = 3'h6
	} pes_period_type;

	localparam pes_period_type PERIOD_RST = warm_up_period;

endpackage

// file: hw/pes_sync.sv
`timescale 1ns/1ps
module pes_sync (
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	input wire logic [pes_pkg::SENSE_W-1:0] async_in,
	output logic [pes_pkg::SENSE_W-1:0] level_out,
	output logic [pes_pkg::SENSE_W-1:0] rise_out,
	output logic [pes_pkg::SENSE_W-1:0] fall_out
);
	import pes_pkg::*;

	typedef struct packed {
		logic [SENSE_W-1:0] meta;
		logic [SENSE_W-1:0] stable;
		logic [SENSE_W-1:0] last;
		logic [SENSE_W-1:0] rise;
		logic [SENSE_W-1:0] fall;
	} pes_sync_type;

	pes_sync_type cur;
	pes_sync_type next_cur;

	////////////////////////////////////////////////////////////////////////////////
	// three flops, then edges taken from the second and third only
	always_comb begin
		next_cur = cur;
		next_cur.meta = async_in;
		next_cur.stable = cur.meta;
		next_cur.last = cur.stable;
		next_cur.rise = cur.stable & ~cur.last;
		next_cur.fall = ~cur.stable & cur.last;
	end

	// register the state
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			cur <= '{SENSE_RST, SENSE_RST, SENSE_RST, SENSE_RST, SENSE_RST};
		end else begin
			cur <= next_cur;
		end
	end

	assign level_out = cur.last;
	assign rise_out = cur.rise;
	assign fall_out = cur.fall;

endmodule

// file: hw/pes_interval.sv
`timescale 1ns/1ps
module pes_interval (
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	input wire logic sheet_done_in,
	input wire logic [pes_pkg::INTERVAL_W-1:0] interval_in,
	output logic due_out
);
	import pes_pkg::*;

	typedef struct packed {
		logic [INTERVAL_W-1:0] count;
		logic due;
	} pes_interval_type;

	pes_interval_type cur;
	pes_interval_type next_cur;

	////////////////////////////////////////////////////////////////////////////////
	// count finished sheets, pulse when the configured interval is reached
	always_comb begin
		next_cur = cur;
		next_cur.due = 1'b0;
		if (interval_in == INTERVAL_OFF) begin
			next_cur.count = COUNT_RST;
		end else if (sheet_done_in) begin
			if (cur.count + COUNT_ONE >= interval_in) begin
				next_cur.count = COUNT_RST;
				next_cur.due = 1'b1;
			end else begin
				next_cur.count = cur.count + COUNT_ONE;
			end
		end
	end

	// register the state
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			cur <= '{COUNT_RST, 1'b0};
		end else begin
			cur <= next_cur;
		end
	end

	assign due_out = cur.due;

endmodule

// file: verification/pes_sequencer_monitor.sv
`timescale 1ns/1ps
module pes_sequencer_monitor
	import pes_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	input wire logic print_cmd_in,
	input wire logic sleep_cmd_in,
	input wire logic reg_cal_cmd_in,
	input wire logic door_closed_in,
	input wire logic paper_picked_in,
	input wire logic fuser_paper_in,
	input wire pes_pkg::pes_period_type period_out,
	input wire logic drum_discharge_out,
	input wire logic belt_clean_out,
	input wire logic supply_sense_out,
	input wire logic reg_cal_run_out,
	input wire logic stab_cal_run_out,
	input wire logic motor_run_out,
	input wire logic pickup_out,
	input wire logic engine_ready_out,
	input wire logic sleeping_out
);
	logic door_d;
	logic [2:0] quiet;
	logic calm;
	////////////////////////////////////////////////////////////////////////////////
	// cycles since the door pin last moved, so a door edge never races a command
	always_ff @(posedge ref_clk_in) begin
		door_d <= door_closed_in;
		if (sys_rst_in || door_closed_in != door_d) quiet <= 3'h0;
		else if (quiet != 3'h7) quiet <= quiet + 3'h1;
	end
	assign calm = (quiet == 3'h7);
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (sys_rst_in);
	////////////////////////////////////////////////////////////////////////////////
	// period sequencing, calibration and output level checks
	chk_reset_warm: assert property (disable iff (1'b0)
		sys_rst_in |=> period_out == warm_up_period) else $error("reset left warm-up");
	chk_print_start: assert property (
		period_out == idle_ready_period && print_cmd_in && !reg_cal_run_out && !stab_cal_run_out
		&& calm |=> period_out == initial_rotation_period && pickup_out && motor_run_out)
		else $error("print not taken in idle");
	chk_pick_edge: assert property (
		period_out == printing_period && $past(period_out) == initial_rotation_period
		|-> $past(paper_picked_in, 4) && !$past(paper_picked_in, 5)) else $error("early print");
	chk_trail_edge: assert property (
		period_out == last_rotation_period && $past(period_out) == printing_period
		|-> !$past(fuser_paper_in, 4) && $past(fuser_paper_in, 5)) else $error("early stop");
	chk_relaunch: assert property (
		period_out == last_rotation_period && print_cmd_in && calm
		|=> period_out == initial_rotation_period) else $error("reprint not direct");
	chk_sleep_idle: assert property (
		period_out == last_rotation_period && sleep_cmd_in && !print_cmd_in && calm
		|=> period_out == idle_ready_period && sleeping_out) else $error("sleep ignored");
	chk_cal_cause: assert property (
		$rose(reg_cal_run_out) |-> $past(reg_cal_cmd_in) || period_out == warm_up_period
		|| $past(period_out) == warm_up_period) else $error("uncommanded calibration");
	chk_cal_single: assert property (!(reg_cal_run_out && stab_cal_run_out))
		else $error("two calibrations at once");
	chk_warm_work: assert property (
		period_out == warm_up_period && $past(period_out) == warm_up_period && !$past(sys_rst_in)
		|-> drum_discharge_out && belt_clean_out && supply_sense_out) else $error("warm-up idle");
	chk_motor_rest: assert property (
		period_out == idle_ready_period || period_out == last_rotation_period |-> !motor_run_out)
		else $error("motor driven at rest");
	chk_ready_idle: assert property (
		engine_ready_out == (period_out == idle_ready_period)) else $error("ready flag wrong");
	cover property (period_out == last_rotation_period ##1 period_out == initial_rotation_period);
	cover property ($rose(stab_cal_run_out));
	cover property ($rose(sleeping_out));
	cover property (period_out == warm_up_period && reg_cal_run_out);
endmodule
bind pes_sequencer pes_sequencer_monitor u_mon (.*);

// file: verification/pes_fmt_model.sv
`timescale 1ns/1ps
module pes_fmt_model (
	input wire logic ref_clk_in,
	output logic print_cmd_out,
	output logic sleep_cmd_out,
	output logic reg_cal_cmd_out,
	output logic stab_cal_cmd_out,
	output logic stab_time_out
);
	////////////////////////////////////////////////////////////////////////////////
	// one-cycle command pulses; mask bits print, sleep, reg, stab, stab time
	initial {stab_time_out, stab_cal_cmd_out, reg_cal_cmd_out, sleep_cmd_out, print_cmd_out} = 5'h00;
	task automatic issue(input logic [4:0] mask);
		@(negedge ref_clk_in);
		{stab_time_out, stab_cal_cmd_out, reg_cal_cmd_out, sleep_cmd_out, print_cmd_out} = mask;
		@(negedge ref_clk_in);
		{stab_time_out, stab_cal_cmd_out, reg_cal_cmd_out, sleep_cmd_out, print_cmd_out} = 5'h00;
		@(negedge ref_clk_in);
	endtask
endmodule

// file: verification/pes_sequencer_tb.sv
`timescale 1ns/1ps
module pes_sequencer_tb;
	import pes_pkg::*;
	logic ref_clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic prt, slp_c, reg_c, stab_c, stab_t;
	logic [INTERVAL_W-1:0] interval;
	logic door, phase, pick, fuser, motor, cal;
	pes_period_type period;
	logic dis, padj, belt, sup, rcal, scal, mot, pku, img, rdy, slp;
	int mismatches = 0;
	int n_checks = 0;
	int cycles = 0;
	always #50 ref_clk_in = ~ref_clk_in;
	pes_fmt_model u_fmt (.ref_clk_in(ref_clk_in), .print_cmd_out(prt), .sleep_cmd_out(slp_c),
		.reg_cal_cmd_out(reg_c), .stab_cal_cmd_out(stab_c), .stab_time_out(stab_t));
	pes_sequencer u_dut (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .print_cmd_in(prt),
		.sleep_cmd_in(slp_c), .reg_cal_cmd_in(reg_c), .stab_cal_cmd_in(stab_c),
		.stab_time_in(stab_t), .stab_interval_in(interval), .door_closed_in(door),
		.phase_done_in(phase), .paper_picked_in(pick), .fuser_paper_in(fuser),
		.motor_stopped_in(motor), .cal_done_in(cal), .period_out(period),
		.drum_discharge_out(dis), .phase_adjust_out(padj), .belt_clean_out(belt),
		.supply_sense_out(sup), .reg_cal_run_out(rcal), .stab_cal_run_out(scal),
		.motor_run_out(mot), .pickup_out(pku), .image_form_out(img),
		.engine_ready_out(rdy), .sleeping_out(slp));
	////////////////////////////////////////////////////////////////////////////////
	// verdict, comparison and waiting helpers
	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wait_per(input pes_period_type p, input int lim);
		for (int i = 0; i < lim && period !== p; i++) @(negedge ref_clk_in);
		check("period", 8'(period), 8'(p));
	endtask
	task automatic cal_pulse;
		cal = 1'b1;
		repeat (5) @(negedge ref_clk_in);
		cal = 1'b0;
		repeat (5) @(negedge ref_clk_in);
	endtask
	// one sheet from initial rotation to last rotation, optional timed stabilisation
	task automatic run_sheet(input logic stab);
		pick = 1'b1;
		fuser = 1'b1;
		wait_per(printing_period, 8);
		check("image", 8'(img), 8'h01);
		if (stab) begin
			u_fmt.issue(5'h10);
			check("stab run", 8'(scal), 8'h01);
		end
		pick = 1'b0;
		fuser = 1'b0;
		wait_per(last_rotation_period, 8);
		check("motor", 8'(mot), 8'h00);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_warm;
		repeat (10) @(negedge ref_clk_in);
		check("period", 8'(period), 8'(warm_up_period));
		check("warm work", 8'({dis, belt, sup, padj}), 8'h0f);
		phase = 1'b1;
		wait_per(idle_ready_period, 8);
		check("ready", 8'(rdy), 8'h01);
	endtask
	task automatic t_cal;
		repeat (10) @(negedge ref_clk_in);
		check("idle hold", 8'({period, rcal}), 8'({idle_ready_period, 1'b0}));
		u_fmt.issue(5'h04);
		check("reg run", 8'({rcal, scal}), 8'h02);
		u_fmt.issue(5'h08);
		check("busy stab", 8'(scal), 8'h00);
		cal_pulse();
		check("reg end", 8'(rcal), 8'h00);
	endtask
	task automatic t_print;
		u_fmt.issue(5'h01);
		wait_per(initial_rotation_period, 2);
		repeat (8) @(negedge ref_clk_in);
		check("pick wait", 8'({period, pku, mot}), 8'({initial_rotation_period, 2'b11}));
		run_sheet(1'b1);
		motor = 1'b1;
		wait_per(idle_ready_period, 8);
		cal_pulse();
		check("stab end", 8'(scal), 8'h00);
	endtask
	task automatic t_again;
		motor = 1'b0;
		u_fmt.issue(5'h01);
		run_sheet(1'b0);
		u_fmt.issue(5'h01);
		check("reprint", 8'(period), 8'(initial_rotation_period));
		u_fmt.issue(5'h02);
		check("sleep", 8'({period, slp}), 8'({idle_ready_period, 1'b1}));
	endtask
	task automatic t_door;
		door = 1'b0;
		repeat (6) @(negedge ref_clk_in);
		door = 1'b1;
		wait_per(warm_up_period, 6);
		check("sleep clear", 8'(slp), 8'h00);
		wait_per(idle_ready_period, 12);
		sys_rst_in = 1'b1;
		@(negedge ref_clk_in);
		check("reset", 8'(period), 8'(warm_up_period));
		sys_rst_in = 1'b0;
		wait_per(idle_ready_period, 20);
	endtask
	// calibration asked during warm-up starts there, and warm-up holds until it ends
	task automatic t_pend;
		door = 1'b0;
		phase = 1'b0;
		repeat (4) @(negedge ref_clk_in);
		door = 1'b1;
		wait_per(warm_up_period, 6);
		u_fmt.issue(5'h04);
		check("warm pend", 8'({period, rcal, padj}), 8'({warm_up_period, 2'b11}));
		phase = 1'b1;
		repeat (8) @(negedge ref_clk_in);
		check("warm hold", 8'(period), 8'(warm_up_period));
		cal_pulse();
		check("warm done", 8'({period, rcal}), 8'({idle_ready_period, 1'b0}));
	endtask
	// stability after every second sheet, sleep in last rotation, idle stability command
	task automatic t_interval;
		interval = 8'h02;
		u_fmt.issue(5'h01);
		run_sheet(1'b0);
		repeat (2) @(negedge ref_clk_in);
		check("one sheet", 8'(scal), 8'h00);
		u_fmt.issue(5'h01);
		run_sheet(1'b0);
		@(negedge ref_clk_in);
		check("interval", 8'(scal), 8'h01);
		u_fmt.issue(5'h02);
		check("last sleep", 8'({period, slp}), 8'({idle_ready_period, 1'b1}));
		cal_pulse();
		u_fmt.issue(5'h08);
		check("idle stab", 8'({rcal, scal}), 8'h01);
		u_fmt.issue(5'h01);
		check("print held", 8'(period), 8'(idle_ready_period));
		cal_pulse();
		check("print after", 8'({period, scal}), 8'({initial_rotation_period, 1'b0}));
		u_fmt.issue(5'h02);
		check("rot sleep", 8'(period), 8'(idle_ready_period));
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// run sequence and hang guard
	always @(posedge ref_clk_in) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			end_sim();
		end
	end
	initial begin
		interval = 8'h00;
		{door, phase, pick, fuser, motor, cal} = 6'h20;
		repeat (6) @(negedge ref_clk_in);
		sys_rst_in = 1'b0;
		t_warm();
		t_cal();
		t_print();
		t_again();
		t_door();
		t_pend();
		t_interval();
		end_sim();
	end
endmodule
